//--- rtl/atci_top.sv
// Dual-channel TDM PCM/ADPCM serial framing with per-frame control sampling
`timescale 1ns/1ps
`default_nettype none
module atci_top
	import atci_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              host_mode_strap_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [DATA_W-1:0] reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [DATA_W-1:0] reg_rdata_out,
	input  wire logic              bit_clock_chan_x_in,
	input  wire logic              frame_sync_chan_x_in,
	input  wire logic              serial_in_chan_x_in,
	output logic                   serial_out_chan_x_out,
	output logic                   serial_out_chan_x_oe_b_out,
	input  wire logic              bit_clock_chan_y_in,
	input  wire logic              frame_sync_chan_y_in,
	input  wire logic              serial_in_chan_y_in,
	output logic                   serial_out_chan_y_out,
	output logic                   serial_out_chan_y_oe_b_out
);
	import atci_pkg::*;

	logic              strap_s1_ff;
	logic              strap_s2_ff;
	logic [2:0]        upd_cnt_ff;
	logic              busy_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [1:0]        bclk_w;
	logic [1:0]        fs_w;
	logic [1:0]        din_w;

	assign bclk_w = {bit_clock_chan_y_in, bit_clock_chan_x_in};
	assign fs_w   = {frame_sync_chan_y_in, frame_sync_chan_x_in};
	assign din_w  = {serial_in_chan_y_in, serial_in_chan_x_in};

	// Slot window test: true when bit count c lies inside slot sl
	function automatic logic in_slot(input logic [CNT_W-1:0] c, input logic [5:0] sl,
		input logic w8, input logic law);
		logic [CNT_W-1:0] st;
		logic [6:0]       lim;
		st  = w8 ? CNT_W'({sl, 3'h0}) : CNT_W'({sl, 2'h0});
		lim = w8 ? (law ? SLOTS_PCM_ULAW : SLOTS_PCM_ALAW)
			: (law ? SLOTS_ADPCM_ULAW : SLOTS_ADPCM_ALAW);
		in_slot = ({1'b0, sl} < lim) && (c >= st) && (c < st + (w8 ? PCM_BITS : ADPCM_BITS));
	endfunction

	// Stand-in transcoding: MSB-first word, top nibble used for ADPCM
	function automatic logic [7:0] proc_word(input logic [7:0] s, input logic cdir,
		input logic [2:0] rate, input logic pad);
		logic [7:0] w;
		w = {s[7:4], 4'h0};
		case (rate)
			RATE_24K: w = {s[7:5], cdir & pad, 4'h0};
			RATE_16K: w = {s[7:6], 6'h00};
			default:  w = {s[7:4], 4'h0};
		endcase
		proc_word = w;
	endfunction

	// Strap synchroniser; low selects hardware mode
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			strap_s1_ff <= 1'b0;
			strap_s2_ff <= 1'b0;
		end else begin
			strap_s1_ff <= host_mode_strap_in;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// Update-in-progress window opened by every register write
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			upd_cnt_ff <= 3'h0;
			busy_ff    <= 1'b0;
		end else begin
			if (reg_wr_in) begin
				upd_cnt_ff <= UPD_HOLD_CYC;
			end else if (upd_cnt_ff != 3'h0) begin
				upd_cnt_ff <= upd_cnt_ff - 3'h1;
			end
			busy_ff <= reg_wr_in || (upd_cnt_ff > 3'h1);
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			localparam logic [3:0] BASE = (ch == 0) ? OFS_CH_X : OFS_CH_Y;
			logic             lclk;
			logic [7:0]       ctrl_ff;
			logic [5:0]       islot_ff;
			logic [5:0]       oslot_ff;
			logic             tgl_ff;
			logic             pend_ff;
			logic             sig_s1_ff;
			logic             sig_s2_ff;
			logic             lrst1_ff;
			logic             lrst2_ff;
			logic             tgl_s1_ff;
			logic             tgl_s2_ff;
			logic             tgl_s3_ff;
			logic             busy_s1_ff;
			logic             busy_s2_ff;
			logic             hm_s1_ff;
			logic             hm_s2_ff;
			logic [19:0]      cfg_ff;
			logic [19:0]      act_ff;
			logic             act_hm_ff;
			logic             fs_prev_ff;
			logic             run_ff;
			logic [CNT_W-1:0] cnt_ff;
			logic             dbl_ff;
			logic [7:0]       sr_ff;
			logic [7:0]       done_ff;
			logic [7:0]       src_ff;
			logic             so_ff;
			logic             oe_b_ff;
			logic             fs_rise;
			logic [CNT_W-1:0] nxt_cnt;
			logic [19:0]      nxt_act;
			logic             nxt_hm;
			logic [7:0]       nxt_src;
			logic             nxt_dbl;
			logic [2:0]       prog_rate;
			logic [2:0]       eff_rate;
			logic [5:0]       in_sl;
			logic [5:0]       out_sl;
			logic [7:0]       word;
			logic [7:0]       sr_nxt;

			assign lclk = bclk_w[ch];

			// Register writes; accepted with no serial clock involved
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					ctrl_ff  <= CTRL_RST;
					islot_ff <= SLOT_RST;
					oslot_ff <= SLOT_RST;
					tgl_ff   <= 1'b0;
					pend_ff  <= 1'b0;
				end else if (reg_wr_in) begin
					if (reg_addr_in == BASE + OFS_CTRL) begin
						ctrl_ff <= reg_wdata_in;
					end
					if (reg_addr_in == BASE + OFS_IN_SLOT) begin
						islot_ff <= reg_wdata_in[5:0];
					end
					if (reg_addr_in == BASE + OFS_OUT_SLOT) begin
						oslot_ff <= reg_wdata_in[5:0];
					end
					if (reg_addr_in[3:2] == BASE[3:2]) begin
						pend_ff <= 1'b1;
					end
				end else if (upd_cnt_ff == 3'h1 && pend_ff) begin // Toggle once writes settle, none lost
					pend_ff <= 1'b0;
					tgl_ff  <= ~tgl_ff;
				end
			end

			// Signaling-frame level into the register domain
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					sig_s1_ff <= 1'b0;
					sig_s2_ff <= 1'b0;
				end else begin
					sig_s1_ff <= dbl_ff;
					sig_s2_ff <= sig_s1_ff;
				end
			end

			// Link-side reset release, synchronous to the bit clock
			always_ff @(posedge lclk or negedge rst_b_in) begin
				if (!rst_b_in) begin
					lrst1_ff <= 1'b0;
					lrst2_ff <= 1'b0;
				end else begin
					lrst1_ff <= 1'b1;
					lrst2_ff <= lrst1_ff;
				end
			end

			// Crossings into the bit clock domain; config word taken on toggle
			always_ff @(posedge lclk or negedge lrst2_ff) begin
				if (!lrst2_ff) begin
					tgl_s1_ff  <= 1'b0;
					tgl_s2_ff  <= 1'b0;
					tgl_s3_ff  <= 1'b0;
					busy_s1_ff <= 1'b0;
					busy_s2_ff <= 1'b0;
					hm_s1_ff   <= 1'b0;
					hm_s2_ff   <= 1'b0;
					cfg_ff     <= 20'h00000;
				end else begin
					tgl_s1_ff  <= tgl_ff;
					tgl_s2_ff  <= tgl_s1_ff;
					tgl_s3_ff  <= tgl_s2_ff;
					busy_s1_ff <= busy_ff;
					busy_s2_ff <= busy_s1_ff;
					hm_s1_ff   <= strap_s2_ff;
					hm_s2_ff   <= hm_s1_ff;
					if (tgl_s2_ff != tgl_s3_ff) begin
						cfg_ff <= {ctrl_ff, islot_ff, oslot_ff};
					end
				end
			end

			// Frame timing and per-sample settings
			always_comb begin
				fs_rise   = fs_w[ch] && !fs_prev_ff;
				nxt_cnt   = fs_rise ? {CNT_W{1'b0}} : ((cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 1'b1);
				nxt_act   = fs_rise ? cfg_ff : act_ff;
				nxt_hm    = fs_rise ? hm_s2_ff : act_hm_ff;
				nxt_src   = fs_rise ? done_ff : src_ff;
				nxt_dbl   = !fs_rise && (dbl_ff || (fs_w[ch] && fs_prev_ff));
				prog_rate = {nxt_act[12 + CTRL_RSEL_HIGH_BIT], nxt_act[12 + CTRL_RSEL_MID_BIT],
					nxt_act[12 + CTRL_RSEL_LOW_BIT]};
				eff_rate  = (prog_rate == RATE_32K && nxt_dbl) ? RATE_24K : prog_rate;
				in_sl     = nxt_hm ? act_ff[11:6] : SLOT_RST;
				out_sl    = nxt_hm ? nxt_act[5:0] : SLOT_RST;
				word      = proc_word(nxt_src, nxt_act[12 + CTRL_CODE_DIR_BIT], eff_rate,
					nxt_hm && (prog_rate == RATE_24K));
				sr_nxt    = {sr_ff[6:0], din_w[ch]};
			end

			// Bit counter, sync width detection and sample hand-off
			always_ff @(posedge lclk or negedge lrst2_ff) begin
				if (!lrst2_ff) begin
					fs_prev_ff <= 1'b0;
					run_ff     <= 1'b0;
					cnt_ff     <= {CNT_W{1'b0}};
					dbl_ff     <= 1'b0;
					act_ff     <= 20'h00000;
					act_hm_ff  <= 1'b0;
					src_ff     <= 8'h00;
				end else begin
					fs_prev_ff <= fs_w[ch];
					run_ff     <= run_ff || fs_rise;
					cnt_ff     <= nxt_cnt;
					dbl_ff     <= nxt_dbl;
					act_ff     <= nxt_act;
					act_hm_ff  <= nxt_hm;
					src_ff     <= nxt_src;
				end
			end

			// Input capture: width set by direction only
			always_ff @(posedge lclk or negedge lrst2_ff) begin
				if (!lrst2_ff) begin
					sr_ff   <= 8'h00;
					done_ff <= 8'h00;
				end else if (run_ff && !fs_rise &&
					in_slot(cnt_ff, in_sl, act_ff[12 + CTRL_CODE_DIR_BIT], act_ff[12 + CTRL_LAW_BIT])) begin
					sr_ff <= sr_nxt;
					if (act_ff[12 + CTRL_CODE_DIR_BIT] && cnt_ff[2:0] == 3'h7) begin
						done_ff <= sr_nxt;
					end else if (!act_ff[12 + CTRL_CODE_DIR_BIT] && cnt_ff[1:0] == 2'h3) begin
						done_ff <= {sr_nxt[3:0], 4'h0};
					end
				end
			end

			// Output drive, floating outside slot, when idle or updating
			always_ff @(posedge lclk or negedge lrst2_ff) begin
				if (!lrst2_ff) begin
					so_ff   <= 1'b0;
					oe_b_ff <= 1'b1;
				end else if ((run_ff || fs_rise) && !busy_s2_ff && !nxt_act[12 + CTRL_IDLE_BIT] &&
					in_slot(nxt_cnt, out_sl, !nxt_act[12 + CTRL_CODE_DIR_BIT], nxt_act[12 + CTRL_LAW_BIT])) begin
					so_ff   <= nxt_act[12 + CTRL_CODE_DIR_BIT] ? word[3'h7 - {1'b0, nxt_cnt[1:0]}]
						: word[3'h7 - nxt_cnt[2:0]];
					oe_b_ff <= 1'b0;
				end else begin
					so_ff   <= 1'b0;
					oe_b_ff <= 1'b1;
				end
			end
		end
	endgenerate

	// Register read, data one cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				OFS_CH_X + OFS_CTRL:     rdata_ff <= g_ch[0].ctrl_ff;
				OFS_CH_X + OFS_IN_SLOT:  rdata_ff <= {2'h0, g_ch[0].islot_ff};
				OFS_CH_X + OFS_OUT_SLOT: rdata_ff <= {2'h0, g_ch[0].oslot_ff};
				OFS_CH_Y + OFS_CTRL:     rdata_ff <= g_ch[1].ctrl_ff;
				OFS_CH_Y + OFS_IN_SLOT:  rdata_ff <= {2'h0, g_ch[1].islot_ff};
				OFS_CH_Y + OFS_OUT_SLOT: rdata_ff <= {2'h0, g_ch[1].oslot_ff};
				OFS_STATUS: begin
					rdata_ff <= 8'h00;
					rdata_ff[STAT_HOST_MODE_BIT] <= strap_s2_ff;
					rdata_ff[STAT_SIG_X_BIT]     <= g_ch[0].sig_s2_ff;
					rdata_ff[STAT_SIG_Y_BIT]     <= g_ch[1].sig_s2_ff;
				end
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata_out              = rdata_ff;
	assign serial_out_chan_x_out      = g_ch[0].so_ff;
	assign serial_out_chan_x_oe_b_out = g_ch[0].oe_b_ff;
	assign serial_out_chan_y_out      = g_ch[1].so_ff;
	assign serial_out_chan_y_oe_b_out = g_ch[1].oe_b_ff;
endmodule
`default_nettype wire

//--- shared/atci_pkg.sv
// Constants for the dual-channel TDM PCM/ADPCM framing block
package atci_pkg;
	// Register port widths and map
	localparam int unsigned ADDR_W      = 4;
	localparam int unsigned DATA_W      = 8;
	localparam logic [3:0]  OFS_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_IN_SLOT = 4'h1;
	localparam logic [3:0]  OFS_OUT_SLOT = 4'h2;
	localparam logic [3:0]  OFS_CH_X    = 4'h0;
	localparam logic [3:0]  OFS_CH_Y    = 4'h4;
	localparam logic [3:0]  OFS_STATUS  = 4'h8;
	// Channel control register fields
	localparam int unsigned CTRL_CODE_DIR_BIT  = 0;
	localparam int unsigned CTRL_RSEL_HIGH_BIT = 1;
	localparam int unsigned CTRL_LAW_BIT       = 2;
	localparam int unsigned CTRL_IDLE_BIT      = 5;
	localparam int unsigned CTRL_RSEL_MID_BIT  = 6;
	localparam int unsigned CTRL_RSEL_LOW_BIT  = 7;
	localparam logic [2:0]  RATE_32K = 3'h0;
	localparam logic [2:0]  RATE_24K = 3'h7;
	localparam logic [2:0]  RATE_16K = 3'h5;
	// Reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [5:0]  SLOT_RST = 6'h00;
	// Status register fields
	localparam int unsigned STAT_HOST_MODE_BIT = 0;
	localparam int unsigned STAT_SIG_X_BIT     = 1;
	localparam int unsigned STAT_SIG_Y_BIT     = 2;
	// Sample widths and slot counts per law
	localparam int unsigned CNT_W = 10;
	localparam logic [CNT_W-1:0] CNT_MAX   = 10'h3ff;
	localparam logic [CNT_W-1:0] PCM_BITS  = 10'h008;
	localparam logic [CNT_W-1:0] ADPCM_BITS = 10'h004;
	localparam logic [6:0]  SLOTS_PCM_ULAW   = 7'h20;
	localparam logic [6:0]  SLOTS_ADPCM_ULAW = 7'h40;
	localparam logic [6:0]  SLOTS_PCM_ALAW   = 7'h20;
	localparam logic [6:0]  SLOTS_ADPCM_ALAW = 7'h40;
	// Output tri-state hold after a register write
	localparam int unsigned CLK_MHZ      = 20;
	localparam int unsigned UPD_HOLD_NS  = 200;
	localparam logic [2:0]  UPD_HOLD_CYC = 3'((UPD_HOLD_NS * CLK_MHZ + 999) / 1000);
endpackage

//--- bench/atci_chk_checker.sv
// Port checker for the TDM framing block
`timescale 1ns/1ps
`default_nettype none
module atci_chk
	import atci_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              reg_rd_in,
	input  wire logic              reg_wr_in,
	input  wire logic [DATA_W-1:0] reg_rdata_out,
	input  wire logic              bit_clock_chan_x_in,
	input  wire logic              bit_clock_chan_y_in,
	input  wire logic              frame_sync_chan_x_in,
	input  wire logic              serial_out_chan_x_out,
	input  wire logic              serial_out_chan_x_oe_b_out,
	input  wire logic              serial_out_chan_y_out,
	input  wire logic              serial_out_chan_y_oe_b_out
);
	// Short aliases for the link side
	wire logic oex = serial_out_chan_x_oe_b_out;
	wire logic oey = serial_out_chan_y_oe_b_out;
	// Cycles since the last register write; a write may legally cut a slot short
	logic [4:0] wr_age_ff;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_age_ff <= 5'h00;
		end else if (reg_wr_in) begin
			wr_age_ff <= 5'h00;
		end else if (wr_age_ff != 5'h1f) begin
			wr_age_ff <= wr_age_ff + 5'h01;
		end
	end
	wire logic wr_quiet = (wr_age_ff == 5'h1f);
	// Frame start, seen one edge after the sync rise
	sequence s_frame_rise_x;
		$past(frame_sync_chan_x_in) && !$past(frame_sync_chan_x_in, 2);
	endsequence
	a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!$past(reg_rd_in) |-> reg_rdata_out == '0) else $error("read data outside a read answer");
	a_float_on_wr: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_wr_in |-> ##[1:16] (oex && oey)) else $error("outputs kept driving during an update");
	a_slot_start_x: assert property (@(posedge bit_clock_chan_x_in) disable iff (!rst_b_in)
		$fell(oex) && wr_quiet |-> s_frame_rise_x) else $error("x output began off the frame start");
	a_min_len_x: assert property (@(posedge bit_clock_chan_x_in) disable iff (!rst_b_in)
		$fell(oex) && wr_quiet |-> (!oex || !wr_quiet) [*4]) else $error("x slot shorter than four bits");
	a_slot_end_x: assert property (@(posedge bit_clock_chan_x_in) disable iff (!rst_b_in)
		$fell(oex) |-> ##[1:8] oex) else $error("x output held past its slot");
	a_slot_end_y: assert property (@(posedge bit_clock_chan_y_in) disable iff (!rst_b_in)
		$fell(oey) |-> ##[1:8] oey) else $error("y output held past its slot");
	a_quiet_x: assert property (@(posedge bit_clock_chan_x_in) disable iff (!rst_b_in)
		oex |-> !serial_out_chan_x_out) else $error("x data not low while floating");
	a_quiet_y: assert property (@(posedge bit_clock_chan_y_in) disable iff (!rst_b_in)
		oey |-> !serial_out_chan_y_out) else $error("y data not low while floating");
endmodule
`default_nettype wire

//--- bench/atci_tdm_model.sv
// TDM line partner: frame sync, serial source and slot capture
`timescale 1ns/1ps
`default_nettype none
module atci_tdm_model #(parameter int FRAME = 16) (
	input  wire logic       bclk_in,
	input  wire logic       rst_b_in,
	input  wire logic [7:0] word_in,
	input  wire logic       dbl_in,
	input  wire logic       sout_in,
	input  wire logic       oe_b_in,
	output logic            fs_out,
	output logic            sdata_out,
	output logic [7:0]      rx_out,
	output logic [3:0]      nbits_out,
	output logic [4:0]      phase_out
);
	logic fs_seen;
	// Launch sync and MSB-first data just after each bit clock edge
	always_ff @(posedge bclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_out <= 5'h00;
			fs_out <= 1'h0;
			sdata_out <= 1'h0;
		end else begin
			phase_out <= (phase_out == 5'(FRAME - 1)) ? 5'h00 : phase_out + 5'h01;
			fs_out <= (phase_out == 5'(FRAME - 1)) || (dbl_in && phase_out == 5'h00);
			sdata_out <= (phase_out < 5'h08) ? word_in[3'(7 - phase_out)] : ~sdata_out;
		end
	end
	// Shift in the returned slot, cleared at each frame start
	always_ff @(posedge bclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_out <= 8'h00;
			nbits_out <= 4'h0;
			fs_seen <= 1'h0;
		end else begin
			fs_seen <= fs_out;
			if (fs_out && !fs_seen) begin
				rx_out <= 8'h00;
				nbits_out <= 4'h0;
			end else if (!oe_b_in) begin
				rx_out <= {rx_out[6:0], sout_in};
				nbits_out <= nbits_out + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/adpcm_tdm_channel_io_bench.sv
// Testbench for the TDM framing block
`timescale 1ns/1ps
`default_nettype none
module adpcm_tdm_channel_io_bench;
	import atci_pkg::*;
	typedef struct packed {logic s; logic ch; logic [7:0] ctl; logic [7:0] wd; logic d; logic [7:0] ex; logic [3:0] w;} atci_row_t;
	logic              clk_in = 1'h0, rst_b_in = 1'h0, host_mode_strap_in = 1'h1;
	logic [ADDR_W-1:0] reg_addr_in = '0;
	logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out, d;
	logic              reg_wr_in = 1'h0, reg_rd_in = 1'h0, bit_clock_chan_x_in = 1'h0;
	logic              frame_sync_chan_x_in, serial_in_chan_x_in, serial_out_chan_x_out, serial_out_chan_x_oe_b_out;
	logic              frame_sync_chan_y_in, serial_in_chan_y_in, serial_out_chan_y_out, serial_out_chan_y_oe_b_out;
	logic [7:0]        word_x = 8'hf0, word_y = 8'hb0, rx_x, rx_y;
	logic              dbl_x = 1'h0, dbl_y = 1'h0;
	logic [3:0]        nb_x, nb_y;
	logic [4:0]        phase;
	wire logic         bit_clock_chan_y_in = bit_clock_chan_x_in;
	int                num_errors = 0, samples_checked = 0;
	atci_row_t         r;
	// strap, chan, ctrl, word, double, expected, width
	atci_row_t rows [10] = '{
		'{1'h1, 1'h0, 8'h01, 8'hf0, 1'h0, 8'h0f, 4'h4},
		'{1'h1, 1'h0, 8'hc7, 8'he0, 1'h0, 8'h0f, 4'h4},
		'{1'h1, 1'h0, 8'h87, 8'hf0, 1'h0, 8'h0c, 4'h4},
		'{1'h1, 1'h0, 8'h05, 8'hf0, 1'h1, 8'h0e, 4'h4},
		'{1'h0, 1'h0, 8'hc7, 8'he0, 1'h0, 8'h0e, 4'h4},
		'{1'h0, 1'h0, 8'h05, 8'hf0, 1'h1, 8'h0e, 4'h4},
		'{1'h1, 1'h1, 8'h04, 8'hb0, 1'h0, 8'hb0, 4'h8},
		'{1'h1, 1'h1, 8'hc6, 8'hb0, 1'h0, 8'ha0, 4'h8},
		'{1'h1, 1'h1, 8'h86, 8'hf0, 1'h0, 8'hc0, 4'h8},
		'{1'h1, 1'h1, 8'h04, 8'hb0, 1'h1, 8'ha0, 4'h8}};
	atci_top i_dut (.*);
	atci_tdm_model i_px (.bclk_in(bit_clock_chan_x_in), .rst_b_in(rst_b_in), .word_in(word_x), .dbl_in(dbl_x),
		.sout_in(serial_out_chan_x_out), .oe_b_in(serial_out_chan_x_oe_b_out), .fs_out(frame_sync_chan_x_in),
		.sdata_out(serial_in_chan_x_in), .rx_out(rx_x), .nbits_out(nb_x), .phase_out(phase));
	atci_tdm_model i_py (.bclk_in(bit_clock_chan_y_in), .rst_b_in(rst_b_in), .word_in(word_y), .dbl_in(dbl_y),
		.sout_in(serial_out_chan_y_out), .oe_b_in(serial_out_chan_y_oe_b_out), .fs_out(frame_sync_chan_y_in),
		.sdata_out(serial_in_chan_y_in), .rx_out(rx_y), .nbits_out(nb_y), .phase_out());
	// Clocks: register side 50 ns, link side 80 ns with an offset
	always #25 clk_in = ~clk_in;
	initial begin
		#13;
		forever #40 bit_clock_chan_x_in = ~bit_clock_chan_x_in;
	end
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'h0;
		#1 v = reg_rdata_out;
	endtask
	// Wait for the given frame phase, n frames in turn
	task automatic at_phase(input int n, input logic [4:0] p);
		repeat (n) begin
			@(posedge bit_clock_chan_x_in);
			while (phase !== p) @(posedge bit_clock_chan_x_in);
		end
		@(posedge clk_in);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		final_report;
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'h1;
		rd(OFS_CH_X | OFS_CTRL, d);
		check("ctrl_x reset", CTRL_RST, d);
		foreach (rows[i]) begin
			r = rows[i];
			host_mode_strap_in <= r.s;
			if (r.ch) {word_y, dbl_y} <= {r.wd, r.d};
			else {word_x, dbl_x} <= {r.wd, r.d};
			wr(r.ch ? OFS_CH_Y : OFS_CH_X, r.ctl);
			at_phase(3, 5'h0c);
			check("sample", r.ex, r.ch ? rx_y : rx_x);
			check("width", {4'h0, r.w}, r.ch ? {4'h0, nb_y} : {4'h0, nb_x});
		end
		// Status shows software mode and a double-width x frame
		host_mode_strap_in <= 1'h1;
		{word_x, dbl_x, dbl_y} <= {8'hf0, 1'h1, 1'h0};
		wr(OFS_CH_X, 8'h05);
		at_phase(3, 5'h0c);
		rd(OFS_STATUS, d);
		check("status", 8'h03, d);
		rd(OFS_CH_X, d);
		check("ctrl_x", 8'h05, d);
		// Idle channel drives no bits at all
		wr(OFS_CH_X, 8'h25);
		at_phase(3, 5'h0c);
		check("idle width", 8'h00, {4'h0, nb_x});
		wr(OFS_CH_X, 8'h05);
		wr(4'hf, 8'hff);
		rd(4'hf, d);
		check("unmapped", 8'h00, d);
		wr(OFS_CH_X | OFS_IN_SLOT, 8'hc0);
		rd(OFS_CH_X | OFS_IN_SLOT, d);
		check("slot_x", 8'h00, d);
		// Update while y is driving its slot
		wr(OFS_CH_Y, 8'h04);
		at_phase(3, 5'h02);
		check("oe_y in slot", 8'h00, {7'h00, serial_out_chan_y_oe_b_out});
		wr(OFS_CH_Y, 8'h04);
		repeat (6) @(posedge clk_in);
		check("oe_y update", 8'h01, {7'h00, serial_out_chan_y_oe_b_out});
		at_phase(3, 5'h0c);
		check("y after update", 8'hb0, rx_y);
		// Reset in mid-run
		rst_b_in <= 1'h0;
		repeat (8) @(posedge clk_in);
		check("oe_x reset", 8'h01, {7'h00, serial_out_chan_x_oe_b_out});
		rst_b_in <= 1'h1;
		rd(OFS_CH_X, d);
		check("ctrl_x rereset", CTRL_RST, d);
		final_report;
	end
endmodule
bind atci_top atci_chk i_chk (.*);
`default_nettype wire
